// [rtl/sip_pkg.sv]
// Purpose: constants for the system I/O port bank
// Assumes: 16-bit host I/O address, 8-bit data
// Notes:   offsets are host I/O byte addresses
package sip_pkg;
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam logic [15:0] KBD_CODE_OFS    = 16'h0060;
	localparam logic [15:0] SYS_CTRL_OFS    = 16'h0061;
	localparam logic [15:0] SPLIT_IO_OFS    = 16'h0062;
	localparam logic [15:0] DMA_PAGE_BASE   = 16'h0080;
	localparam logic [15:0] NMI_MASK_BASE   = 16'h00A0;
	localparam logic [1:0]  DMA_PAGE_CH2    = 2'h1;
	localparam logic [1:0]  DMA_PAGE_CH3    = 2'h2;
	localparam logic [1:0]  DMA_PAGE_CH01   = 2'h3;
	localparam int          CTRL_GATE_BIT   = 0;
	localparam int          CTRL_SPK_BIT    = 1;
	localparam int          CTRL_SEL_LO_BIT = 5;
	localparam int          CTRL_SEL_HI_BIT = 6;
	localparam int          CTRL_CLR_BIT    = 7;
	localparam int          SPLIT_DATA_BIT  = 1;
	localparam int          SPLIT_CLK_BIT   = 2;
	localparam int          SPLIT_TMR_BIT   = 5;
	localparam logic [7:0]  CTRL_RST        = 8'h00;
	localparam logic [3:0]  SPLIT_OUT_RST   = 4'h0;
	localparam logic [7:0]  KBD_RST         = 8'h00;
	localparam logic [7:0]  RELEASE_OFS     = 8'h80;
endpackage

// [rtl/sip_sync2.sv]
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: sys_clk domain
// Notes:   first stage feeds only the second
`timescale 1ns/100ps
module sip_sync2 #(
	parameter int W = 1
) (
	input  wire logic         sys_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg <= '0;
			q        <= '0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // sip_sync2

// [rtl/sip_port_bank.sv]
// Purpose: system I/O port bank on the host I/O bus
// Assumes: synchronous one-cycle read and write strobes from host logic
// Notes:   page and mask registers are decoded only, selects to outside
//
// Overview of operation
// - Keyboard port reads latched eight-bit code
// - Control port readable, returns last written value
// - Control bit 0 enables timer 2 gate
// - Control bit 1 drives speaker data
// - Control bits 2-4 have no function
// - Control bits 5,6 are sound select
// - Writing control bit 7 clears keyboard code unless a new code latches in that cycle
// - Third port accepts writes and reads
// - Third port low nibble out, high in
// - Third port bit 1 drives serial data
// - Third port bit 2 drives serial clock
// - Third port bit 5 returns timer 2
// - Page select from A3-A15, A0-A1 passed
// - Channel 0,1 page at fourth location
// - Mask register ignores A0 to A2
`timescale 1ns/100ps
module sip_port_bank
	import sip_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] io_addr,
	input  wire logic [DATA_W-1:0] io_wdata,
	input  wire logic              io_wr,
	input  wire logic              io_rd,
	output logic      [DATA_W-1:0] io_rdata,
	output logic                   io_rvalid,
	input  wire logic [DATA_W-1:0] kbd_code,
	input  wire logic              kbd_strobe,
	input  wire logic              timer2_out,
	output logic                   timer2_gate,
	output logic                   speaker_data,
	output logic                   sound_select_lo,
	output logic                   sound_select_hi,
	output logic                   kbd_clear,
	output logic                   multi_data,
	output logic                   multi_clock,
	output logic                   dma_page_cs,
	output logic      [1:0]        dma_page_idx,
	output logic                   dma_page_ch01,
	output logic                   nmi_mask_cs
);
	// ****************************************
	// Elaboration checks
	// ****************************************
	if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_width
		$error("port bank serves only a 16-bit address and 8-bit data");
	end

	// ****************************************
	// Decode
	// ****************************************
	function automatic logic match_mask(input logic [15:0] a, input logic [15:0] base,
		input int ign);
		logic [15:0] m;
		m = 16'hFFFF << ign;
		return (a & m) == (base & m);
	endfunction

	logic       sel_kbd;
	logic       sel_ctrl;
	logic       sel_split;
	logic       sel_page;
	logic       sel_nmi;
	logic [7:0] ctrl_reg;
	logic [3:0] split_out_reg;
	logic [7:0] kbd_reg;
	logic       tmr_sync;
	logic       kstb_sync;
	logic       kstb_d_reg;
	logic [7:0] kcode_sync;

	assign sel_kbd   = io_addr == KBD_CODE_OFS;
	assign sel_ctrl  = io_addr == SYS_CTRL_OFS;
	assign sel_split = io_addr == SPLIT_IO_OFS;
	assign sel_page  = match_mask(io_addr, DMA_PAGE_BASE, 3);
	assign sel_nmi   = match_mask(io_addr, NMI_MASK_BASE, 3);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	sip_sync2 #(.W(10)) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.d       ({timer2_out, kbd_strobe, kbd_code}),
		.q       ({tmr_sync, kstb_sync, kcode_sync})
	);

	// ****************************************
	// Control and third port registers
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RST;
		end else if (io_wr && sel_ctrl) begin
			ctrl_reg <= io_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			split_out_reg <= SPLIT_OUT_RST;
		end else if (io_wr && sel_split) begin
			split_out_reg <= io_wdata[3:0];
		end
	end

	// ****************************************
	// Keyboard code latch
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			kstb_d_reg <= 1'b0;
			kbd_reg    <= KBD_RST;
		end else begin
			kstb_d_reg <= kstb_sync;
			if (kstb_sync && !kstb_d_reg) begin
				kbd_reg <= kcode_sync;
			end else if (io_wr && sel_ctrl && io_wdata[CTRL_CLR_BIT]) begin
				kbd_reg <= KBD_RST;
			end
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			timer2_gate     <= 1'b0;
			speaker_data    <= 1'b0;
			sound_select_lo <= 1'b0;
			sound_select_hi <= 1'b0;
			kbd_clear       <= 1'b0;
			multi_data      <= 1'b0;
			multi_clock     <= 1'b0;
		end else begin
			timer2_gate     <= ctrl_reg[CTRL_GATE_BIT];
			speaker_data    <= ctrl_reg[CTRL_SPK_BIT];
			sound_select_lo <= ctrl_reg[CTRL_SEL_LO_BIT];
			sound_select_hi <= ctrl_reg[CTRL_SEL_HI_BIT];
			kbd_clear       <= io_wr && sel_ctrl && io_wdata[CTRL_CLR_BIT];
			multi_data      <= split_out_reg[SPLIT_DATA_BIT];
			multi_clock     <= split_out_reg[SPLIT_CLK_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_page_cs   <= 1'b0;
			dma_page_idx  <= 2'h0;
			dma_page_ch01 <= 1'b0;
			nmi_mask_cs   <= 1'b0;
		end else begin
			dma_page_cs   <= (io_wr || io_rd) && sel_page;
			dma_page_idx  <= io_addr[1:0];
			dma_page_ch01 <= (io_wr || io_rd) && sel_page
				&& io_addr[1:0] == DMA_PAGE_CH01;
			nmi_mask_cs   <= (io_wr || io_rd) && sel_nmi;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			io_rdata  <= 8'h00;
			io_rvalid <= 1'b0;
		end else begin
			io_rvalid <= io_rd && (sel_kbd || sel_ctrl || sel_split);
			if (!io_rd) begin
				io_rdata <= 8'h00;
			end else if (sel_kbd) begin
				io_rdata <= kbd_reg;
			end else if (sel_ctrl) begin
				io_rdata <= ctrl_reg;
			end else if (sel_split) begin
				io_rdata <= {2'b00, tmr_sync, 1'b0, split_out_reg};
			end else begin
				io_rdata <= 8'h00;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	chk_ctrl_readback: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && sel_ctrl ##1 io_rd && sel_ctrl && !io_wr |=> io_rdata == $past(io_wdata, 2))
		else $error("control readback mismatch");
	chk_gate_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && sel_ctrl |=> ##1 timer2_gate == $past(io_wdata[0], 2))
		else $error("timer gate wrong");
	chk_speaker_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && sel_ctrl |=> ##1 speaker_data == $past(io_wdata[1], 2))
		else $error("speaker data wrong");
	chk_sound_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && sel_ctrl |=> ##1 {sound_select_hi, sound_select_lo} == $past(io_wdata[6:5], 2))
		else $error("sound select wrong");
	chk_kbd_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && sel_ctrl && io_wdata[7] && !(kstb_sync && !kstb_d_reg) |=> kbd_reg == 8'h00)
		else $error("keyboard clear missed");
	chk_serial_lines: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && sel_split |=> ##1 {multi_clock, multi_data} == $past(io_wdata[2:1], 2))
		else $error("serial lines wrong");
	chk_split_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_rd && sel_split |=> io_rdata[5] == $past(tmr_sync) && io_rdata[7:6] == 2'b00)
		else $error("split read wrong");
	chk_page_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_rd && io_addr[15:3] == 13'h0010 |=> dma_page_cs)
		else $error("page select missed");
	chk_nmi_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
		io_wr && io_addr[15:3] == 13'h0014 |=> nmi_mask_cs)
		else $error("mask select missed");

	// ****************************************
	// Check sequences
	// ****************************************
	sequence seq_ctrl_write;
		io_wr && sel_ctrl;
	endsequence
	sequence seq_split_write;
		io_wr && sel_split;
	endsequence
	sequence seq_split_readback;
		seq_split_write ##1 (io_rd && sel_split && !io_wr);
	endsequence
	sequence seq_split_read;
		io_rd && sel_split;
	endsequence
	sequence seq_kbd_latch;
		kstb_sync && !kstb_d_reg;
	endsequence
	sequence seq_kbd_read;
		io_rd && sel_kbd;
	endsequence

	// ****************************************
	// Keyboard checks
	// ****************************************
	property prop_kbd_latch;
		@(posedge sys_clk) disable iff (!rst_n)
		seq_kbd_latch |=> kbd_reg == $past(kcode_sync);
	endproperty
	chk_kbd_latch: assert property (prop_kbd_latch)
		else $error("keyboard code not latched");
	property prop_kbd_read;
		@(posedge sys_clk) disable iff (!rst_n)
		seq_kbd_read |=> io_rvalid && io_rdata == $past(kbd_reg);
	endproperty
	chk_kbd_read: assert property (prop_kbd_read)
		else $error("keyboard read wrong");
	property prop_kbd_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		!(kstb_sync && !kstb_d_reg) && !(io_wr && sel_ctrl && io_wdata[CTRL_CLR_BIT])
			|=> $stable(kbd_reg);
	endproperty
	chk_kbd_hold: assert property (prop_kbd_hold)
		else $error("keyboard code changed");
	property prop_clear_pulse;
		@(posedge sys_clk) disable iff (!rst_n)
		seq_ctrl_write |=> kbd_clear == $past(io_wdata[CTRL_CLR_BIT]);
	endproperty
	chk_clear_pulse: assert property (prop_clear_pulse)
		else $error("keyboard clear pulse wrong");
	property prop_clear_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		!(io_wr && sel_ctrl) |=> !kbd_clear;
	endproperty
	chk_clear_quiet: assert property (prop_clear_quiet)
		else $error("keyboard clear without write");

	// ****************************************
	// Port checks
	// ****************************************
	property prop_ctrl_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		!(io_wr && sel_ctrl) |=> $stable(ctrl_reg);
	endproperty
	chk_ctrl_hold: assert property (prop_ctrl_hold)
		else $error("control port changed");
	property prop_split_hold;
		@(posedge sys_clk) disable iff (!rst_n)
		!(io_wr && sel_split) |=> $stable(split_out_reg);
	endproperty
	chk_split_hold: assert property (prop_split_hold)
		else $error("split outputs changed");
	property prop_split_readback;
		@(posedge sys_clk) disable iff (!rst_n)
		seq_split_readback |=> io_rvalid && io_rdata[3:0] == $past(io_wdata[3:0], 2);
	endproperty
	chk_split_readback: assert property (prop_split_readback)
		else $error("split readback wrong");
	property prop_split_upper;
		@(posedge sys_clk) disable iff (!rst_n)
		seq_split_read |=> io_rvalid && io_rdata[4] == 1'b0;
	endproperty
	chk_split_upper: assert property (prop_split_upper)
		else $error("split unused input set");
	property prop_rvalid_map;
		@(posedge sys_clk) disable iff (!rst_n)
		io_rd && (io_addr == KBD_CODE_OFS || io_addr == SYS_CTRL_OFS
			|| io_addr == SPLIT_IO_OFS) |=> io_rvalid;
	endproperty
	chk_rvalid_map: assert property (prop_rvalid_map)
		else $error("port read not answered");

	// ****************************************
	// Decode checks
	// ****************************************
	property prop_page_idx;
		@(posedge sys_clk) disable iff (!rst_n)
		(io_rd || io_wr) && io_addr[15:3] == DMA_PAGE_BASE[15:3]
			|=> dma_page_cs && dma_page_idx == $past(io_addr[1:0]);
	endproperty
	chk_page_idx: assert property (prop_page_idx)
		else $error("page index wrong");
	property prop_page_ch01;
		@(posedge sys_clk) disable iff (!rst_n)
		(io_rd || io_wr) && io_addr[15:3] == DMA_PAGE_BASE[15:3]
			&& io_addr[1:0] == DMA_PAGE_CH01 |=> dma_page_ch01;
	endproperty
	chk_page_ch01: assert property (prop_page_ch01)
		else $error("channel 0,1 page missed");
	property prop_page_outside;
		@(posedge sys_clk) disable iff (!rst_n)
		(io_rd || io_wr) && io_addr[15:3] != DMA_PAGE_BASE[15:3]
			|=> !dma_page_cs && !dma_page_ch01;
	endproperty
	chk_page_outside: assert property (prop_page_outside)
		else $error("page select outside group");
	property prop_nmi_alias;
		@(posedge sys_clk) disable iff (!rst_n)
		(io_rd || io_wr) && io_addr[15:3] != NMI_MASK_BASE[15:3] |=> !nmi_mask_cs;
	endproperty
	chk_nmi_alias: assert property (prop_nmi_alias)
		else $error("mask select outside group");
	property prop_page_quiet;
		@(posedge sys_clk) disable iff (!rst_n)
		!io_rd && !io_wr |=> !dma_page_cs && !dma_page_ch01 && !nmi_mask_cs;
	endproperty
	chk_page_quiet: assert property (prop_page_quiet)
		else $error("select without access");
endmodule // sip_port_bank

// [sim/sip_host_model.sv]
// Purpose: host I/O bus model for the port bank
// Assumes: one-cycle strobes launched at the falling edge
// Notes:   released address and data lines show the inverse of their last value, strobes go low
`timescale 1ns/100ps
module sip_host_model
	import sip_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic [DATA_W-1:0] io_rdata,
	input  wire logic              io_rvalid,
	output logic      [ADDR_W-1:0] io_addr,
	output logic      [DATA_W-1:0] io_wdata,
	output logic                   io_wr,
	output logic                   io_rd
);
	initial begin
		io_addr = 16'h0000;
		io_wdata = 8'h00;
		io_wr = 1'b0;
		io_rd = 1'b0;
	end
	// One access, answer sampled while it stands
	task automatic access(input logic [15:0] a, input logic [7:0] d, input logic w,
		output logic [7:0] q, output logic v);
		@(negedge sys_clk);
		io_addr = a;
		io_wdata = d;
		io_wr = w;
		io_rd = ~w;
		@(negedge sys_clk);
		q = io_rdata;
		v = io_rvalid;
		io_wr = 1'b0;
		io_rd = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
	// Write, then read the same address on the next edge
	task automatic wr_rd(input logic [15:0] a, input logic [7:0] d, output logic [7:0] q,
		output logic v);
		@(negedge sys_clk);
		io_addr = a;
		io_wdata = d;
		io_wr = 1'b1;
		io_rd = 1'b0;
		@(negedge sys_clk);
		io_wr = 1'b0;
		io_rd = 1'b1;
		@(negedge sys_clk);
		q = io_rdata;
		v = io_rvalid;
		io_rd = 1'b0;
		io_addr = ~a;
		io_wdata = ~d;
	endtask
endmodule // sip_host_model

// [sim/tb_sip_port_bank.sv]
// Purpose: self-checking bench for the port bank
// Assumes: host model drives the bus, bench drives pins
// Notes:   pins change at the falling edge
`timescale 1ns/100ps
module tb_sip_port_bank import sip_pkg::*; ;
	logic              sys_clk = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] io_addr;
	logic [DATA_W-1:0] io_wdata, io_rdata, q, kbd_code = 8'h00;
	logic              io_wr, io_rd, io_rvalid, v, kbd_strobe = 1'b0, timer2_out = 1'b0;
	logic              timer2_gate, speaker_data, sound_select_lo, sound_select_hi;
	logic              kbd_clear, multi_data, multi_clock, dma_page_cs, dma_page_ch01;
	logic              nmi_mask_cs, seen;
	logic [1:0]        dma_page_idx;
	int                errors = 0;
	int                checks_done = 0;
	always #2 sys_clk = ~sys_clk;
	sip_port_bank i_dut (.sys_clk, .rst_n, .io_addr, .io_wdata, .io_wr, .io_rd, .io_rdata,
		.io_rvalid, .kbd_code, .kbd_strobe, .timer2_out, .timer2_gate, .speaker_data,
		.sound_select_lo, .sound_select_hi, .kbd_clear, .multi_data, .multi_clock,
		.dma_page_cs, .dma_page_idx, .dma_page_ch01, .nmi_mask_cs);
	sip_host_model i_host (.sys_clk, .io_rdata, .io_rvalid, .io_addr, .io_wdata, .io_wr,
		.io_rd);
	task automatic complete_run();
		$display("checks_done=%0d errors=%0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e, input logic ok);
		i_host.access(a, 8'h00, 1'b0, q, v);
		check8("rvalid", {7'h00, ok}, {7'h00, v});
		check8("rdata", e, q);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		i_host.access(a, d, 1'b1, q, v);
		@(negedge sys_clk);
	endtask
	task automatic wr_then_rd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] e);
		i_host.wr_rd(a, d, q, v);
		check8("rvalid", 8'h01, {7'h00, v});
		check8("rdata", e, q);
	endtask
	task automatic kbd_send(input logic [7:0] c);
		kbd_code = c;
		kbd_strobe = 1'b1;
		repeat (6) @(negedge sys_clk);
		kbd_strobe = 1'b0;
		repeat (6) @(negedge sys_clk);
	endtask
	task automatic t_ctrl();
		logic [7:0] tbl [4] = '{8'h63, 8'h1C, 8'h21, 8'h42};
		foreach (tbl[i]) begin
			wr(SYS_CTRL_OFS, tbl[i]);
			check8("ctrl pins", {4'h0, tbl[i][CTRL_GATE_BIT], tbl[i][CTRL_SPK_BIT],
				tbl[i][CTRL_SEL_LO_BIT], tbl[i][CTRL_SEL_HI_BIT]}, {4'h0, timer2_gate,
				speaker_data, sound_select_lo, sound_select_hi});
			rd(SYS_CTRL_OFS, tbl[i], 1'b1);
		end
		wr_then_rd(SYS_CTRL_OFS, 8'h55, 8'h55);
	endtask
	task automatic t_kbd();
		kbd_send(8'h1E);
		rd(KBD_CODE_OFS, 8'h1E, 1'b1);
		kbd_send(8'h1E + RELEASE_OFS);
		rd(KBD_CODE_OFS, 8'h9E, 1'b1);
		wr(KBD_CODE_OFS, 8'h55);
		rd(KBD_CODE_OFS, 8'h9E, 1'b1);
		i_host.access(SYS_CTRL_OFS, 8'h80, 1'b1, q, v);
		seen = kbd_clear;
		repeat (2) @(negedge sys_clk) seen |= kbd_clear;
		check8("kbd_clear", 8'h01, {7'h00, seen});
		rd(KBD_CODE_OFS, 8'h00, 1'b1);
		rd(SYS_CTRL_OFS, 8'h80, 1'b1);
	endtask
	task automatic t_split();
		logic [7:0] tbl [2] = '{8'hF6, 8'h09};
		foreach (tbl[i]) begin
			timer2_out = tbl[i][7];
			wr(SPLIT_IO_OFS, tbl[i]);
			check8("split pins", {6'h00, tbl[i][SPLIT_CLK_BIT], tbl[i][SPLIT_DATA_BIT]},
				{6'h00, multi_clock, multi_data});
			rd(SPLIT_IO_OFS, {2'b00, tbl[i][7], 1'b0, tbl[i][3:0]}, 1'b1);
		end
		wr_then_rd(SPLIT_IO_OFS, 8'h5A, {2'b00, timer2_out, 1'b0, 4'hA});
	endtask
	task automatic t_decode();
		logic [15:0] tbl [8] = '{16'h0083, 16'h0081, 16'h0086, 16'h0088, 16'h00A0,
			16'h00A7, 16'h00A8, 16'h0180};
		logic cs;
		foreach (tbl[i]) begin
			cs = tbl[i][15:3] == DMA_PAGE_BASE[15:3];
			i_host.access(tbl[i], 8'h00, i[0], q, v);
			check8("selects", {3'h0, cs, cs && tbl[i][1:0] == DMA_PAGE_CH01,
				tbl[i][15:3] == NMI_MASK_BASE[15:3], tbl[i][1:0] & {2{cs}}},
				{3'h0, dma_page_cs, dma_page_ch01, nmi_mask_cs,
				dma_page_idx & {2{cs}}});
		end
		rd(16'h0070, 8'h00, 1'b0);
	endtask
	task automatic t_reset(input logic pulse);
		if (pulse) begin
			wr(SYS_CTRL_OFS, 8'h63);
			wr(SPLIT_IO_OFS, 8'h06);
			kbd_send(8'h2C);
			rst_n = 1'b0;
			repeat (2) @(negedge sys_clk);
			rst_n = 1'b1;
		end
		@(negedge sys_clk);
		check8("reset pins", 8'h00, {1'b0, timer2_gate, speaker_data, sound_select_lo,
			sound_select_hi, kbd_clear, multi_data, multi_clock});
		rd(SYS_CTRL_OFS, CTRL_RST, 1'b1);
		rd(SPLIT_IO_OFS, {4'h0, SPLIT_OUT_RST}, 1'b1);
		rd(KBD_CODE_OFS, KBD_RST, 1'b1);
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		rst_n = 1'b1;
		t_reset(1'b0);
		t_ctrl();
		t_kbd();
		t_split();
		t_reset(1'b1);
		t_decode();
		complete_run();
	end
	initial begin
		#20000;
		errors++;
		complete_run();
	end
endmodule // tb_sip_port_bank
